/* verilog/dual_serial_port_pin_logic.sv */
// Purpose: Pin logic of a dual two-wire / four-wire serial port with limit alert.
// Assumes: sclk is the serial clock pin also seen as scl_in; din shares the data pin.
// Notes: Port defaults to two-wire; a chip-select fall locks the four-wire mode.
// Operation
// - In four-wire mode read data leaves on the data output, changing on falling serial clock.
// - In four-wire mode input data is sampled on the rising serial clock edge.
// - The serial clock shifts data out of any register and into writable ones only.
// - The target address comes from the three-state select pin: low 48h, float 4Ah, high 4Bh.
// - The address is latched on the eighth clock of the second valid address transfer.
// - Once latched, later changes on the select pin leave the address unchanged.
// - Round-robin mode steps through every channel, one measurement each, in order.
// - Chip select is active low, frames each transfer, and input is taken only while low.
// - The port starts in two-wire mode and stays locked in four-wire once selected.
module dual_serial_port_pin_logic
  import pin_logic_pkg::*;
(
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  output logic dout_out,
  output logic dout_oe,
  input wire logic [1:0] addr_pin_state,
  input wire logic [CHANNEL_COUNT-1:0] limit_exceed,
  input wire logic [CHANNEL_COUNT-1:0] limit_enable,
  input wire logic alert_active_high,
  output logic alert_out,
  output logic alert_oe,
  input wire logic monitor_enable,
  input wire logic conversion_done,
  output logic [3:0] channel_sel,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_we,
  input wire logic reg_writable,
  input wire logic [7:0] reg_rdata,
  output logic spi_mode,
  output logic addr_locked,
  output logic [6:0] i2c_address
);
  typedef struct packed {
    logic spi_mode;
    logic [1:0] cs_sync;
    logic cs_prev;
    logic [1:0] scl_sync;
    logic [1:0] sda_sync;
    logic scl_prev;
    logic sda_prev;
    logic [1:0] rdy_sync;
    logic [1:0] wr_sync;
    logic rdy_prev;
    logic wr_prev;
    logic [1:0] pin_first;
    logic [1:0] pin_second;
    i2c_state_t st;
    logic [3:0] bit_cnt;
    logic [7:0] shift;
    logic first_byte;
    logic is_read;
    logic matched;
    logic bump;
    logic rd_acked;
    logic [1:0] valid_cnt;
    logic addr_locked;
    logic [6:0] locked_addr;
    logic sda_oe;
    logic [7:0] reg_addr;
    logic [7:0] wdata;
    logic we;
    logic [7:0] spi_rd;
    logic alert;
    logic [3:0] channel;
  } core_state_t;

  core_state_t state_reg;
  core_state_t state_next;
  spi_link_if link_bus ();

  logic scl_rise;
  logic scl_fall;
  logic sda_bit;
  logic bus_start;
  logic bus_stop;
  logic rdy_rise;
  logic wr_rise;
  logic cs_fall;
  logic [6:0] target_addr;
  logic violation;

  spi_link u_spi_link (
    .sclk(sclk),
    .cs_n(cs_n),
    .din(sda_in),
    .link(link_bus.link)
  );

  assign scl_rise = state_reg.scl_sync[1] & ~state_reg.scl_prev;
  assign scl_fall = ~state_reg.scl_sync[1] & state_reg.scl_prev;
  assign sda_bit = state_reg.sda_sync[1];
  assign bus_start = state_reg.scl_sync[1] & state_reg.scl_prev & state_reg.sda_prev & ~sda_bit;
  assign bus_stop = state_reg.scl_sync[1] & state_reg.scl_prev & ~state_reg.sda_prev & sda_bit;
  assign rdy_rise = state_reg.rdy_sync[1] & ~state_reg.rdy_prev;
  assign wr_rise = state_reg.wr_sync[1] & ~state_reg.wr_prev;
  assign cs_fall = state_reg.cs_prev & ~state_reg.cs_sync[1];
  // Before latching, the live pin decides the target
  assign target_addr = state_reg.addr_locked ? state_reg.locked_addr :
    pin_address(state_reg.pin_second);
  assign violation = |(limit_exceed & limit_enable);

  always_comb begin
    state_next = state_reg;
    state_next.we = 1'b0;
    state_next.cs_sync = {state_reg.cs_sync[0], cs_n};
    state_next.cs_prev = state_reg.cs_sync[1];
    state_next.scl_sync = {state_reg.scl_sync[0], scl_in};
    state_next.sda_sync = {state_reg.sda_sync[0], sda_in};
    state_next.scl_prev = state_reg.scl_sync[1];
    state_next.sda_prev = state_reg.sda_sync[1];
    state_next.rdy_sync = {state_reg.rdy_sync[0], link_bus.addr_ready};
    state_next.wr_sync = {state_reg.wr_sync[0], link_bus.wr_done};
    state_next.rdy_prev = state_reg.rdy_sync[1];
    state_next.wr_prev = state_reg.wr_sync[1];
    state_next.pin_first = addr_pin_state;
    state_next.pin_second = state_reg.pin_first;
    state_next.spi_rd = reg_rdata;

    // A tied-high or tied-low chip select never shows a fall
    if (cs_fall) begin
      state_next.spi_mode = 1'b1;
      state_next.st = I2C_IDLE;
      state_next.sda_oe = 1'b0;
    end

    if (state_reg.spi_mode) begin
      // A lock taken mid-transfer must not leave the data line pulled low
      state_next.st = I2C_IDLE;
      state_next.sda_oe = 1'b0;
      // Command word is stable while its ready level is high
      if (rdy_rise) begin
        state_next.reg_addr = {1'b0, link_bus.cmd_addr[6:0]};
      end
      if (wr_rise && !link_bus.cmd_addr[SPI_READ_FLAG]) begin
        state_next.we = reg_writable;
        state_next.wdata = link_bus.wr_data;
      end
    end else if (bus_start) begin
      state_next.st = I2C_ADDR;
      state_next.bit_cnt = BIT_CNT_ZERO;
      state_next.sda_oe = 1'b0;
    end else if (bus_stop) begin
      state_next.st = I2C_IDLE;
      state_next.sda_oe = 1'b0;
    end else begin
      case (state_reg.st)
        I2C_IDLE: begin
          state_next.sda_oe = 1'b0;
        end
        I2C_ADDR: begin
          if (scl_rise) begin
            state_next.shift = {state_reg.shift[6:0], sda_bit};
            state_next.bit_cnt = state_reg.bit_cnt + BIT_CNT_STEP;
            if (state_reg.bit_cnt == BYTE_LAST_BIT) begin
              state_next.is_read = sda_bit;
              state_next.first_byte = 1'b1;
              state_next.bump = 1'b0;
              state_next.matched = (state_reg.shift[6:0] == target_addr);
              if (state_reg.shift[6:0] == target_addr && !state_reg.addr_locked) begin
                if (state_reg.valid_cnt == VALID_BEFORE_LATCH) begin
                  state_next.addr_locked = 1'b1;
                  state_next.locked_addr = pin_address(state_reg.pin_second);
                end else begin
                  state_next.valid_cnt = state_reg.valid_cnt + VALID_STEP;
                end
              end
            end
          end else if (scl_fall && state_reg.bit_cnt == BYTE_BITS) begin
            state_next.sda_oe = state_reg.matched;
            state_next.st = state_reg.matched ? I2C_ACK : I2C_IDLE;
          end
        end
        I2C_ACK: begin
          if (scl_fall) begin
            state_next.sda_oe = 1'b0;
            state_next.bit_cnt = BIT_CNT_ZERO;
            if (state_reg.bump) begin
              state_next.reg_addr = state_reg.reg_addr + POINTER_STEP;
              state_next.bump = 1'b0;
            end
            state_next.st = state_reg.is_read ? I2C_LOAD : I2C_WRITE;
          end
        end
        I2C_WRITE: begin
          if (scl_rise) begin
            state_next.shift = {state_reg.shift[6:0], sda_bit};
            state_next.bit_cnt = state_reg.bit_cnt + BIT_CNT_STEP;
            if (state_reg.bit_cnt == BYTE_LAST_BIT) begin
              if (state_reg.first_byte) begin
                state_next.reg_addr = {state_reg.shift[6:0], sda_bit};
                state_next.first_byte = 1'b0;
              end else begin
                state_next.we = reg_writable;
                state_next.wdata = {state_reg.shift[6:0], sda_bit};
                state_next.bump = 1'b1;
              end
            end
          end else if (scl_fall && state_reg.bit_cnt == BYTE_BITS) begin
            state_next.sda_oe = 1'b1;
            state_next.st = I2C_ACK;
          end
        end
        I2C_LOAD: begin
          // Pointer settled last cycle, so the read data matches it
          state_next.shift = reg_rdata;
          state_next.sda_oe = ~reg_rdata[7];
          state_next.bit_cnt = BIT_CNT_ZERO;
          state_next.st = I2C_READ;
        end
        I2C_READ: begin
          if (scl_rise) begin
            state_next.bit_cnt = state_reg.bit_cnt + BIT_CNT_STEP;
          end else if (scl_fall) begin
            if (state_reg.bit_cnt == BYTE_BITS) begin
              state_next.sda_oe = 1'b0;
              state_next.st = I2C_MACK;
            end else begin
              state_next.shift = {state_reg.shift[6:0], 1'b1};
              state_next.sda_oe = ~state_reg.shift[6];
            end
          end
        end
        I2C_MACK: begin
          if (scl_rise) begin
            state_next.rd_acked = ~sda_bit;
          end else if (scl_fall) begin
            if (state_reg.rd_acked) begin
              state_next.reg_addr = state_reg.reg_addr + POINTER_STEP;
              state_next.st = I2C_LOAD;
            end else begin
              state_next.st = I2C_IDLE;
            end
          end
        end
        default: begin
          state_next.st = I2C_IDLE;
          state_next.sda_oe = 1'b0;
        end
      endcase
    end

    state_next.alert = violation;

    if (!monitor_enable) begin
      state_next.channel = FIRST_CHANNEL;
    end else if (conversion_done) begin
      state_next.channel = (state_reg.channel == LAST_CHANNEL) ? FIRST_CHANNEL :
        state_reg.channel + CHANNEL_STEP;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_reg <= '0;
      state_reg.st <= I2C_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  assign link_bus.rd_data = state_reg.spi_rd;
  assign sda_out = 1'b0;
  assign sda_oe = state_reg.sda_oe;
  assign dout_out = 1'b0;
  // Open drain: pull low for a zero only inside a four-wire frame
  assign dout_oe = state_reg.spi_mode & ~cs_n & ~link_bus.dout_bit;
  assign alert_out = 1'b0;
  assign alert_oe = alert_active_high ? ~state_reg.alert : state_reg.alert;
  assign channel_sel = state_reg.channel;
  assign reg_addr = state_reg.reg_addr;
  assign reg_wdata = state_reg.wdata;
  assign reg_we = state_reg.we;
  assign spi_mode = state_reg.spi_mode;
  assign addr_locked = state_reg.addr_locked;
  assign i2c_address = target_addr;

  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);

  sequence s_spi_write_arrives;
    state_reg.spi_mode && wr_rise && !link_bus.cmd_addr[SPI_READ_FLAG] && reg_writable;
  endsequence

  sequence s_addr_byte_end;
    state_reg.st == I2C_ADDR && scl_fall && state_reg.bit_cnt == BYTE_BITS;
  endsequence

  a_spi_lock_sticky: assert property (state_reg.spi_mode |=> state_reg.spi_mode)
    else $error("four-wire lock dropped");

  a_spi_lock_cause: assert property (cs_fall |=> state_reg.spi_mode)
    else $error("chip select fall did not lock four-wire mode");

  a_addr_hold: assert property (state_reg.addr_locked
    |=> state_reg.addr_locked && $stable(state_reg.locked_addr))
    else $error("latched address changed");

  a_addr_latch_second: assert property ($rose(state_reg.addr_locked)
    |-> $past(state_reg.valid_cnt) == VALID_BEFORE_LATCH &&
        state_reg.locked_addr == pin_address($past(state_reg.pin_second)))
    else $error("address latched at wrong transfer or with wrong value");

  a_ack_match: assert property (s_addr_byte_end ##0 state_reg.matched
    |=> state_reg.sda_oe && state_reg.st == I2C_ACK)
    else $error("matching address not acknowledged");

  a_nack_mismatch: assert property (s_addr_byte_end ##0 !state_reg.matched
    |=> !state_reg.sda_oe ##1 !state_reg.sda_oe)
    else $error("foreign address acknowledged");

  a_spi_write_strobe: assert property (s_spi_write_arrives
    |=> reg_we && reg_wdata == $past(link_bus.wr_data))
    else $error("four-wire write not delivered");

  a_write_gate: assert property (reg_we |-> reg_writable)
    else $error("write to read-only register");

  a_alert_level: assert property (violation ##1 $stable(alert_active_high)
    |-> alert_oe == ~alert_active_high)
    else $error("alert not asserted in configured polarity");

  a_channel_step: assert property (monitor_enable && conversion_done
    |=> channel_sel == (($past(channel_sel) == LAST_CHANNEL) ? FIRST_CHANNEL :
        $past(channel_sel) + CHANNEL_STEP))
    else $error("round-robin channel step wrong");
endmodule : dual_serial_port_pin_logic

/* verilog/pin_logic_pkg.sv */
// Purpose: Shared constants, types and decoders for the serial port pin logic.
// Assumes: 200 MHz core clock; serial clock is a separate domain.
// Notes: Address codes are the pin-selected 7-bit target addresses.
package pin_logic_pkg;
  localparam logic [6:0] I2C_ADDR_PIN_LOW = 7'h48;
  localparam logic [6:0] I2C_ADDR_PIN_FLOAT = 7'h4a;
  localparam logic [6:0] I2C_ADDR_PIN_HIGH = 7'h4b;
  localparam logic [1:0] PIN_LOW = 2'h0;
  localparam logic [1:0] PIN_FLOAT = 2'h1;
  localparam logic [1:0] PIN_HIGH = 2'h2;
  localparam logic [3:0] BYTE_LAST_BIT = 4'h7;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] BIT_CNT_ZERO = 4'h0;
  localparam logic [3:0] BIT_CNT_STEP = 4'h1;
  localparam logic [4:0] SPI_CMD_LAST = 5'h07;
  localparam logic [4:0] SPI_DATA_FIRST = 5'h08;
  localparam logic [4:0] SPI_FRAME_LAST = 5'h0f;
  localparam logic [4:0] SPI_FRAME_DONE = 5'h10;
  localparam logic [4:0] SPI_CNT_STEP = 5'h01;
  localparam int SPI_READ_FLAG = 7;
  localparam logic [1:0] VALID_BEFORE_LATCH = 2'h1;
  localparam logic [1:0] VALID_STEP = 2'h1;
  localparam int CHANNEL_COUNT = 9;
  localparam logic [3:0] FIRST_CHANNEL = 4'h0;
  localparam logic [3:0] LAST_CHANNEL = 4'h8;
  localparam logic [3:0] CHANNEL_STEP = 4'h1;
  localparam logic [7:0] POINTER_STEP = 8'h01;

  typedef enum logic [2:0] {
    I2C_IDLE, I2C_ADDR, I2C_ACK, I2C_WRITE, I2C_LOAD, I2C_READ, I2C_MACK
  } i2c_state_t;

  function automatic logic [6:0] pin_address(input logic [1:0] pin);
    case (pin)
      PIN_LOW: pin_address = I2C_ADDR_PIN_LOW;
      PIN_FLOAT: pin_address = I2C_ADDR_PIN_FLOAT;
      PIN_HIGH: pin_address = I2C_ADDR_PIN_HIGH;
      default: pin_address = I2C_ADDR_PIN_HIGH;
    endcase
  endfunction : pin_address
endpackage : pin_logic_pkg

/* verilog/spi_link_if.sv */
// Purpose: Carrier between the serial-clock shifter and the core logic.
// Assumes: Words are held stable while their ready level is high.
// Notes: Levels clear when chip select goes high.
interface spi_link_if;
  logic [7:0] cmd_addr;
  logic [7:0] wr_data;
  logic addr_ready;
  logic wr_done;
  logic dout_bit;
  logic [7:0] rd_data;
  modport link (output cmd_addr, output wr_data, output addr_ready, output wr_done,
    output dout_bit, input rd_data);
  modport core (input cmd_addr, input wr_data, input addr_ready, input wr_done,
    input dout_bit, output rd_data);
endinterface : spi_link_if

/* verilog/spi_link.sv */
// Purpose: Serial-clock side of the four-wire port: command and data shifting.
// Assumes: Frame is one command byte (bit 7 set = read) then one data byte.
// Notes: Chip select high clears the frame state at once.
module spi_link
  import pin_logic_pkg::*;
(
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic din,
  spi_link_if.link link
);
  typedef struct packed {
    logic [4:0] cnt;
    logic [7:0] shift;
    logic [7:0] cmd;
    logic [7:0] wdata;
    logic addr_ready;
    logic wr_done;
  } rise_state_t;

  typedef struct packed {
    logic [7:0] shift;
    logic dout_bit;
  } fall_state_t;

  rise_state_t rise_reg;
  rise_state_t rise_next;
  fall_state_t fall_reg;
  fall_state_t fall_next;

  always_comb begin
    rise_next = rise_reg;
    rise_next.shift = {rise_reg.shift[6:0], din};
    if (rise_reg.cnt != SPI_FRAME_DONE) begin
      rise_next.cnt = rise_reg.cnt + SPI_CNT_STEP;
    end
    if (rise_reg.cnt == SPI_CMD_LAST) begin
      rise_next.cmd = {rise_reg.shift[6:0], din};
      rise_next.addr_ready = 1'b1;
    end
    // A read frame never raises the write level
    if (rise_reg.cnt == SPI_FRAME_LAST && !rise_reg.cmd[SPI_READ_FLAG]) begin
      rise_next.wdata = {rise_reg.shift[6:0], din};
      rise_next.wr_done = 1'b1;
    end
  end

  // Chip select high ends the frame; the clock may stop outside frames
  always_ff @(posedge sclk or posedge cs_n) begin
    if (cs_n) begin
      rise_reg <= '0;
    end else begin
      rise_reg <= rise_next;
    end
  end

  always_comb begin
    fall_next = fall_reg;
    fall_next.dout_bit = 1'b1;
    if (rise_reg.cmd[SPI_READ_FLAG] && rise_reg.cnt == SPI_DATA_FIRST) begin
      fall_next.shift = link.rd_data;
      fall_next.dout_bit = link.rd_data[7];
    end else if (rise_reg.cmd[SPI_READ_FLAG] && rise_reg.cnt > SPI_DATA_FIRST &&
                 rise_reg.cnt <= SPI_FRAME_LAST) begin
      fall_next.shift = {fall_reg.shift[6:0], 1'b1};
      fall_next.dout_bit = fall_reg.shift[6];
    end
  end

  always_ff @(negedge sclk or posedge cs_n) begin
    if (cs_n) begin
      fall_reg <= '{shift: 8'h00, dout_bit: 1'b1};
    end else begin
      fall_reg <= fall_next;
    end
  end

  assign link.cmd_addr = rise_reg.cmd;
  assign link.wr_data = rise_reg.wdata;
  assign link.addr_ready = rise_reg.addr_ready;
  assign link.wr_done = rise_reg.wr_done;
  assign link.dout_bit = fall_reg.dout_bit;

  a_cmd_capture: assert property (@(posedge sclk) disable iff (cs_n)
    rise_reg.cnt == SPI_CMD_LAST |=> rise_reg.addr_ready && rise_reg.cmd[0] == $past(din))
    else $error("command byte not captured on eighth rising edge");

  a_dout_first_bit: assert property (@(negedge sclk) disable iff (cs_n)
    rise_reg.cmd[SPI_READ_FLAG] && rise_reg.cnt == SPI_DATA_FIRST
    |=> fall_reg.dout_bit == $past(link.rd_data[7]))
    else $error("first read bit not shifted on falling edge");
endmodule : spi_link

/* sim/host_master.sv */
// Purpose: Host model that masters the two-wire and four-wire serial pins.
// Assumes: Open-drain lines with pull-ups; serial clock stands still between frames.
// Notes: Half period 80 ns gives the 160 ns link clock; a 1.3 ns skew keeps it off core edges.
module host_master (
  input wire logic sda_oe,
  input wire logic dout_oe,
  output logic scl_pin,
  output logic cs_n,
  output logic data_pin
);
  timeunit 1ns;
  timeprecision 100ps;
  logic host_low;
  // Wired-and over the pull-up: released line reads high
  assign data_pin = ~(host_low | sda_oe);
  initial begin
    scl_pin = 1'b1;
    cs_n = 1'b1;
    host_low = 1'b0;
  end
  task automatic i2c_start();
    #1.3 host_low = 1'b0;
    #40 scl_pin = 1'b1;
    #80 host_low = 1'b1;
    #80 scl_pin = 1'b0;
  endtask : i2c_start
  task automatic i2c_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #20 host_low = ~b[i];
      #60 scl_pin = 1'b1;
      #80 scl_pin = 1'b0;
    end
    #20 host_low = 1'b0;
    #60 scl_pin = 1'b1;
    #40 ack = ~data_pin;
    #40 scl_pin = 1'b0;
  endtask : i2c_byte
  // Host releases data for eight bits, then acks or nacks the byte
  task automatic i2c_read(input logic ack, output logic [7:0] v);
    for (int i = 7; i >= 0; i--) begin
      #20 host_low = 1'b0;
      #60 scl_pin = 1'b1;
      v = {v[6:0], data_pin};
      #80 scl_pin = 1'b0;
    end
    #20 host_low = ack;
    #60 scl_pin = 1'b1;
    #80 scl_pin = 1'b0;
  endtask : i2c_read
  task automatic i2c_stop();
    #20 host_low = 1'b1;
    #60 scl_pin = 1'b1;
    #80 host_low = 1'b0;
    #80;
  endtask : i2c_stop
  task automatic spi_frame(input logic [15:0] bits, input int n, output logic [7:0] rd);
    rd = 8'h00;
    #1.3 scl_pin = 1'b0;
    #100 cs_n = 1'b0;
    #120;
    for (int i = 0; i < n; i++) begin
      #10 host_low = ~bits[15 - i];
      #70 scl_pin = 1'b1;
      if (i >= 8) begin
        rd = {rd[6:0], ~dout_oe};
      end
      #80 scl_pin = 1'b0;
    end
    #40 host_low = 1'b0;
    cs_n = 1'b1;
    #200;
  endtask : spi_frame
endmodule : host_master

/* sim/tb_top.sv */
// Purpose: Self-checking bench for the dual serial port pin logic.
// Assumes: Register file modelled as writable below 30h, read data = address xor 5ah.
// Notes: Random alert and data values come from a fixed seed.
module tb_top
  import pin_logic_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock = 1'b0, sys_rst = 1'b1, scl_pin, cs_n, data_pin, alert_active_high = 1'b0;
  logic [1:0] addr_pin_state = 2'h0;
  logic [CHANNEL_COUNT-1:0] limit_exceed = '0, limit_enable = '0;
  logic monitor_enable = 1'b0, conversion_done = 1'b0, reg_writable, reg_we;
  logic sda_out, sda_oe, dout_out, dout_oe, alert_out, alert_oe, spi_mode, addr_locked, ok;
  logic [3:0] channel_sel;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, we_addr, we_data, rd, p, d, q;
  logic [6:0] i2c_address;
  int n_mismatch = 0, checks = 0, we_cnt = 0, cyc = 0, seed = 45, n0;
  assign reg_writable = reg_addr < 8'h30;
  assign reg_rdata = reg_addr ^ 8'h5a;
  host_master u_host_master (.sda_oe(sda_oe), .dout_oe(dout_oe), .scl_pin(scl_pin),
    .cs_n(cs_n), .data_pin(data_pin));
  dual_serial_port_pin_logic u_dual_serial_port_pin_logic (.clock(clock), .sys_rst(sys_rst),
    .sclk(scl_pin), .cs_n(cs_n), .scl_in(scl_pin), .sda_in(data_pin), .sda_out(sda_out),
    .sda_oe(sda_oe), .dout_out(dout_out), .dout_oe(dout_oe), .addr_pin_state(addr_pin_state),
    .limit_exceed(limit_exceed), .limit_enable(limit_enable),
    .alert_active_high(alert_active_high), .alert_out(alert_out), .alert_oe(alert_oe),
    .monitor_enable(monitor_enable), .conversion_done(conversion_done),
    .channel_sel(channel_sel), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_writable(reg_writable), .reg_rdata(reg_rdata), .spi_mode(spi_mode),
    .addr_locked(addr_locked), .i2c_address(i2c_address));
  initial begin
    forever #2.5 clock = ~clock;
  end
  always @(posedge clock) begin
    if (reg_we === 1'b1) begin
      we_cnt <= we_cnt + 1;
      we_addr <= reg_addr;
      we_data <= reg_wdata;
    end
    cyc <= cyc + 1;
    // Ceiling well above the roughly 8k cycles the tests need
    if (cyc == 60000) begin
      n_mismatch = n_mismatch + 1;
      wrap_up();
    end
  end
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks = checks + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  function automatic logic [6:0] exp_addr(input logic [1:0] s);
    exp_addr = (s == 2'h0) ? 7'h48 : (s == 2'h1) ? 7'h4a : 7'h4b;
  endfunction : exp_addr
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clock);
  endtask : wait_clk
  // Address, pointer, one data byte; ok is the address acknowledge
  task automatic i2c_xfer(input logic [6:0] a, input logic [7:0] pt, input logic [7:0] dt);
    logic k;
    u_host_master.i2c_start();
    u_host_master.i2c_byte({a, 1'b0}, ok);
    if (ok) begin
      u_host_master.i2c_byte(pt, k);
      u_host_master.i2c_byte(dt, k);
    end
    u_host_master.i2c_stop();
    wait_clk(2);
  endtask : i2c_xfer
  initial begin
    wait_clk(12);
    sys_rst <= 1'b0;
    wait_clk(4);
    chk(spi_mode, 0);
    chk(addr_locked, 0);
    chk(channel_sel, 0);
    chk(alert_oe, 0);
    chk({sda_out, dout_out, alert_out, sda_oe, dout_oe}, 5'h00);
    for (int s = 0; s < 4; s++) begin
      addr_pin_state <= s[1:0];
      wait_clk(5);
      chk(i2c_address, exp_addr(s[1:0]));
    end
    $display("test address decode done");
    for (int k = 0; k < 16; k++) begin
      limit_exceed <= (k == 0) ? '1 : CHANNEL_COUNT'($random(seed));
      limit_enable <= (k == 0) ? '0 : CHANNEL_COUNT'($random(seed));
      alert_active_high <= (k < 2) ? 1'b0 : 1'($random(seed));
      wait_clk(3);
      chk(alert_oe, (|(limit_exceed & limit_enable)) ^ alert_active_high);
    end
    $display("test alert done");
    monitor_enable <= 1'b1;
    for (int k = 0; k < 11; k++) begin
      wait_clk(2);
      chk(channel_sel, k % 9);
      conversion_done <= 1'b1;
      wait_clk(1);
      conversion_done <= 1'b0;
    end
    monitor_enable <= 1'b0;
    wait_clk(3);
    chk(channel_sel, 0);
    $display("test round robin done");
    addr_pin_state <= 2'h0;
    wait_clk(5);
    i2c_xfer(7'h4b, 8'h01, 8'h02);
    chk(ok, 0);
    p = 8'($random(seed)) & 8'h2f;
    d = 8'($random(seed));
    n0 = we_cnt;
    i2c_xfer(7'h48, p, d);
    chk(ok, 1);
    chk(we_cnt - n0, 1);
    chk({we_addr, we_data}, {p, d});
    chk(addr_locked, 0);
    i2c_xfer(7'h48, 8'h40, 8'h99);
    chk({ok, addr_locked}, 2'b11);
    chk(we_cnt - n0, 1);
    addr_pin_state <= 2'h2;
    wait_clk(5);
    chk(i2c_address, 7'h48);
    i2c_xfer(7'h4b, 8'h01, 8'h02);
    chk(ok, 0);
    // Pointer sits one past the refused write to 40h; reads step it again
    u_host_master.i2c_start();
    u_host_master.i2c_byte({7'h48, 1'b1}, ok);
    u_host_master.i2c_read(1'b1, q);
    u_host_master.i2c_read(1'b0, rd);
    u_host_master.i2c_stop();
    wait_clk(2);
    chk({ok, q, rd}, {1'b1, 8'h41 ^ 8'h5a, 8'h42 ^ 8'h5a});
    $display("test two-wire done");
    n0 = we_cnt;
    u_host_master.spi_frame({1'b0, p[6:0], ~d}, 16, rd);
    chk(we_cnt - n0, 1);
    chk({we_addr, we_data, spi_mode}, {p, ~d, 1'b1});
    u_host_master.spi_frame({8'h35, d}, 16, rd);
    u_host_master.spi_frame({1'b0, p[6:0], d}, 12, rd);
    chk(we_cnt - n0, 1);
    for (int k = 0; k < 3; k++) begin
      p = (k == 0) ? 8'h7f : 8'($random(seed)) & 8'h7f;
      u_host_master.spi_frame({1'b1, p[6:0], 8'h00}, 16, rd);
      chk(rd, p ^ 8'h5a);
    end
    i2c_xfer(7'h48, 8'h01, 8'h02);
    chk({ok, spi_mode}, 2'b01);
    $display("test four-wire done");
    sys_rst <= 1'b1;
    wait_clk(3);
    sys_rst <= 1'b0;
    wait_clk(4);
    chk({spi_mode, addr_locked}, 2'b00);
    $display("test power cycle done");
    wrap_up();
  end
endmodule : tb_top
